// File: core/gspwm_core.sv
`timescale 1ns/1ps
`include "gspwm_consts.svh"
module gspwm_core
(
    input  wire logic                                CLK,
    input  wire logic                                RSTN,
    input  wire logic                                SERIAL_IN,
    input  wire logic                                SHIFT_CLOCK,
    input  wire logic                                LATCH_STROBE,
    input  wire logic                                BRIGHTNESS_PATH_SELECT,
    input  wire logic                                BLANK,
    input  wire logic                                GRAYSCALE_COUNT_CLOCK,
    output logic [`GSPWM_CHANNELS-1:0]               CHANNEL_SINK_OUTPUT,
    output logic [`GSPWM_BR_WIDTH-2:0]               BRIGHTNESS_LEVEL,
    output logic                                     DISPLAY_ACTIVE
);
    import gspwm_pkg::*;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // three stages for the clocks, strobe and blank, two for serial data and select; stage 1 only feeds stage 2
    logic [2:0] s1, s2, s3;
    wire  [2:0] raw = {GRAYSCALE_COUNT_CLOCK, LATCH_STROBE, SHIFT_CLOCK};
    logic       sin_1, sin_2, sel_1, sel_2, blk_1, blk_2, blk_3;

    always_ff @(posedge CLK)
    begin
        s1 <= raw;
        s2 <= s1;
        s3 <= s2;
        sin_1 <= SERIAL_IN;
        sin_2 <= sin_1;
        sel_1 <= BRIGHTNESS_PATH_SELECT;
        sel_2 <= sel_1;
        blk_1 <= BLANK;
        blk_2 <= blk_1;
        blk_3 <= blk_2;
    end

    // edge when stages two and three disagree, in rising sense except blank_fall
    wire sclk_rise  = s2[0] & ~s3[0];
    wire strb_rise  = s2[1] & ~s3[1];
    wire gclk_rise  = s2[2] & ~s3[2];
    wire blank_rise = blk_2 & ~blk_3;
    wire blank_fall = ~blk_2 & blk_3;
    wire blank_lvl  = blk_3;

    // ------------------------------------------------------------
    // shift registers
    // ------------------------------------------------------------
    gspwm_gs_t gs_shift;
    gspwm_br_t br_shift;
    gspwm_br_t br_first;
    logic [`GSPWM_BR_WIDTH-2:0] br_second;

    always_ff @(posedge CLK)
    begin
        if (sclk_rise && !sel_2)
            gs_shift <= {gs_shift[`GSPWM_GS_WIDTH-2:0], sin_2};
        if (sclk_rise && sel_2)
            br_shift <= {br_shift[`GSPWM_BR_WIDTH-2:0], sin_2};
    end

    // ------------------------------------------------------------
    // display period counter
    // ------------------------------------------------------------
    gspwm_state_e state;
    gspwm_state_e next_state;
    logic [`GSPWM_GS_BITS-1:0] gs_count;
    wire  last_clock = (gs_count == 16'hFFFF);
    wire  repeat_en  = br_first[`GSPWM_REPEAT_BIT];
    wire  period_end = gclk_rise && last_clock && (state == GSPWM_RUN);
    logic run_latched;

    always_comb
    begin
        next_state = state;
        case (state)
            GSPWM_IDLE:
                if (blank_fall)
                    next_state = GSPWM_RUN;
            GSPWM_RUN:
                if (blank_lvl)
                    next_state = GSPWM_IDLE;
                else if (period_end && !repeat_en)
                    next_state = GSPWM_IDLE;
            default:
                next_state = GSPWM_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state    <= GSPWM_IDLE;
            gs_count <= `GSPWM_RESET_VALUE;
        end
        else
        begin
            state <= next_state;
            if (next_state != GSPWM_RUN || state != GSPWM_RUN)
                gs_count <= `GSPWM_RESET_VALUE;
            else if (gclk_rise)
                gs_count <= gs_count + 16'h0001;                   // wraps on repeat
        end
    end

    // ------------------------------------------------------------
    // latch path
    // ------------------------------------------------------------
    gspwm_latch_if lp ();
    assign lp.shift_data = gs_shift;
    assign lp.load_both  = strb_rise && !sel_2 && blank_lvl;
    assign lp.load_first = strb_rise && !sel_2 && !blank_lvl;
    assign lp.refresh    = period_end || blank_rise;

    gspwm_latch_store u_store
    (
        .CLK (CLK),
        .lp  (lp)
    );

    // brightness latches cleared so the level output never shows unknowns
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            br_first  <= '0;
            br_second <= '0;
        end
        else
        begin
        if (strb_rise && sel_2)
            br_first <= br_shift;
        if (strb_rise && sel_2 && blank_lvl)
            br_second <= br_shift[`GSPWM_BR_WIDTH-2:0];
        else if (lp.refresh)
            br_second <= br_first[`GSPWM_BR_WIDTH-2:0];
        end
    end

    // ------------------------------------------------------------
    // spread pulse modulation
    // ------------------------------------------------------------
    // low 7 counter bits pick the display period, upper 9 the slot
    // inside it; value/128 slots plus one extra in value%128 periods
    function automatic logic chan_on(input logic [15:0] val, input logic [15:0] cnt);
        logic [8:0] base;
        logic [6:0] rem;
        logic [6:0] per;
        logic [8:0] slot;
        logic [9:0] len;
        base = val[15:7];
        rem  = val[6:0];
        per  = cnt[6:0];
        slot = cnt[15:7];
        len  = {1'b0, base} + {9'h000, (bit_rev7(per) < rem)};
        chan_on = ({1'b0, slot} < len);
    endfunction : chan_on

    // bit reversal spreads the extra slot evenly over periods
    function automatic logic [6:0] bit_rev7(input logic [6:0] v);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < 7; i++)
            r[i] = v[6-i];
        bit_rev7 = r;
    endfunction : bit_rev7

    logic [`GSPWM_CHANNELS-1:0] next_out;
    always_comb
    begin
        next_out = '0;
        for (int n = 0; n < `GSPWM_CHANNELS; n++)
            next_out[n] = chan_on(lp.second_data[16*n +: 16], gs_count);
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            CHANNEL_SINK_OUTPUT <= '0;
        else if (state != GSPWM_RUN || blank_lvl)
            CHANNEL_SINK_OUTPUT <= '0;
        else
            CHANNEL_SINK_OUTPUT <= next_out;
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            BRIGHTNESS_LEVEL <= '0;
            DISPLAY_ACTIVE   <= 1'b0;
        end
        else
        begin
            BRIGHTNESS_LEVEL <= br_second;
            DISPLAY_ACTIVE   <= (state == GSPWM_RUN);
        end
    end
endmodule : gspwm_core

// File: inc/gspwm_consts.svh
`ifndef GSPWM_CONSTS_SVH
`define GSPWM_CONSTS_SVH
// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define GSPWM_CHANNELS      16
`define GSPWM_GS_BITS       16
`define GSPWM_GS_WIDTH      256
`define GSPWM_BR_WIDTH      8
`define GSPWM_REPEAT_BIT    7
`define GSPWM_SLOT_BITS     9
`define GSPWM_PERIOD_BITS   7
`define GSPWM_RESET_VALUE   16'h0000
`endif

// File: inc/gspwm_pkg.sv
package gspwm_pkg;
    typedef logic [255:0] gspwm_gs_t;
    typedef logic [7:0]   gspwm_br_t;
    typedef enum logic [1:0] {GSPWM_IDLE, GSPWM_RUN} gspwm_state_e;
endpackage : gspwm_pkg

// File: inc/gspwm_latch_if.sv
`timescale 1ns/1ps
interface gspwm_latch_if;
    logic [255:0] shift_data;
    logic         load_first;
    logic         load_both;
    logic         refresh;
    logic [255:0] second_data;
    modport ctrl (output shift_data, output load_first, output load_both, output refresh,
                  input second_data);
    modport store (input shift_data, input load_first, input load_both, input refresh,
                   output second_data);
endinterface : gspwm_latch_if

// File: core/gspwm_latch_store.sv
`timescale 1ns/1ps
`include "gspwm_consts.svh"
module gspwm_latch_store
(
    input  wire logic    CLK,
    gspwm_latch_if.store lp
);
    import gspwm_pkg::*;
    gspwm_gs_t first_latch;
    gspwm_gs_t second_latch;

    always_ff @(posedge CLK)
    begin
        if (lp.load_first || lp.load_both)
            first_latch <= lp.shift_data;
        if (lp.load_both)
            second_latch <= lp.shift_data;
        else if (lp.refresh)
            second_latch <= first_latch;
    end

    // read side registered
    assign lp.second_data = second_latch;
endmodule : gspwm_latch_store

// File: tb/gspwm_assertions.sv
`timescale 1ns/1ps
`include "gspwm_consts.svh"
module gspwm_assertions
(
    input wire logic                       CLK,
    input wire logic                       RSTN,
    input wire logic                       LATCH_STROBE,
    input wire logic                       BLANK,
    input wire logic                       GRAYSCALE_COUNT_CLOCK,
    input wire logic [`GSPWM_CHANNELS-1:0] CHANNEL_SINK_OUTPUT,
    input wire logic [`GSPWM_BR_WIDTH-2:0] BRIGHTNESS_LEVEL,
    input wire logic                       DISPLAY_ACTIVE
);
    logic [3:0] calm;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // outputs may only move a few cycles after a link input moved
    always_ff @(posedge CLK)
        calm <= (!RSTN || $changed(GRAYSCALE_COUNT_CLOCK) || $changed(BLANK)
                 || $changed(LATCH_STROBE)) ? 4'h0 : calm + {3'h0, calm != 4'hF};
    sequence s_blank_held;
        BLANK [*6];
    endsequence
    sequence s_unblanked;
        $fell(BLANK) ##1 !BLANK [*7];
    endsequence
    AST_BLANK_OFF: assert property (s_blank_held |-> CHANNEL_SINK_OUTPUT == 16'h0000)
        else $error("output on while blanked");
    AST_OFF_QUICK: assert property ($rose(BLANK) |-> ##[0:8] CHANNEL_SINK_OUTPUT == 16'h0000)
        else $error("blank did not stop outputs");
    AST_BLANK_IDLE: assert property (s_blank_held |-> !DISPLAY_ACTIVE)
        else $error("display runs while blanked");
    AST_RUN_START: assert property (s_unblanked |-> DISPLAY_ACTIVE)
        else $error("no display period after unblank");
    AST_RUN_CAUSE: assert property ($rose(DISPLAY_ACTIVE) |-> !BLANK)
        else $error("display started while blanked");
    AST_OUT_STANDS: assert property ($changed(CHANNEL_SINK_OUTPUT) |-> calm < 4'hA)
        else $error("output moved without a clock edge");
    AST_LEVEL_STANDS: assert property ($changed(BRIGHTNESS_LEVEL) |-> calm < 4'hA)
        else $error("level moved without strobe or blank");
    AST_RESET_QUIET: assert property ($rose(RSTN) |-> !DISPLAY_ACTIVE)
        else $error("display active at reset release");
endmodule : gspwm_assertions
bind gspwm_core gspwm_assertions u_chk
(
    .CLK(CLK), .RSTN(RSTN), .LATCH_STROBE(LATCH_STROBE), .BLANK(BLANK),
    .GRAYSCALE_COUNT_CLOCK(GRAYSCALE_COUNT_CLOCK), .CHANNEL_SINK_OUTPUT(CHANNEL_SINK_OUTPUT),
    .BRIGHTNESS_LEVEL(BRIGHTNESS_LEVEL), .DISPLAY_ACTIVE(DISPLAY_ACTIVE)
);

// File: tb/gspwm_ctrl_model.sv
`timescale 1ns/1ps
module gspwm_ctrl_model
(
    input  wire logic clk,
    output logic      serial_in,
    output logic      shift_clock,
    output logic      latch_strobe,
    output logic      path_select,
    output logic      gs_clock
);
    initial {serial_in, shift_clock, latch_strobe, path_select, gs_clock} = 5'h00;
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_clk
    // always a whole 256-bit frame; an 8-bit word lands in d[7:0]
    task automatic load(input logic [255:0] d, input logic sel);
        path_select = sel;
        for (int i = 255; i >= 0; i--)
        begin
            serial_in = d[i];
            wait_clk(4);
            shift_clock = 1'b1;
            wait_clk(4);
            shift_clock = 1'b0;
        end
        serial_in = ~d[0];
        latch_strobe = 1'b1;
        wait_clk(4);
        latch_strobe = 1'b0;
        wait_clk(6);
    endtask : load
    task automatic run_gs(input int n);
        repeat (n)
        begin
            wait_clk(4);
            gs_clock = 1'b1;
            wait_clk(4);
            gs_clock = 1'b0;
        end
    endtask : run_gs
endmodule : gspwm_ctrl_model

// File: tb/grayscale_pwm_double_latch_test.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("Error %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module grayscale_pwm_double_latch_test;
    import gspwm_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        blank = 1'b1;
    logic        counting = 1'b0;
    logic        ser, sclk, strobe, sel, grayscale_count_clock, active;
    logic [15:0] out, e;
    logic [6:0]  level;
    logic [7:0]  b;
    logic [15:0] cnt [16];
    logic [15:0] on_q [$];
    logic [7:0]  level_q [$];
    gspwm_gs_t   gs;
    int          mismatches = 0;
    int          n_compared = 0;
    always #10 clk = ~clk;
    gspwm_ctrl_model m (.clk(clk), .serial_in(ser), .shift_clock(sclk),
        .latch_strobe(strobe), .path_select(sel), .gs_clock(grayscale_count_clock));
    gspwm_core dut (.CLK(clk), .RSTN(rstn), .SERIAL_IN(ser), .SHIFT_CLOCK(sclk),
        .LATCH_STROBE(strobe), .BRIGHTNESS_PATH_SELECT(sel), .BLANK(blank),
        .GRAYSCALE_COUNT_CLOCK(grayscale_count_clock), .CHANNEL_SINK_OUTPUT(out),
        .BRIGHTNESS_LEVEL(level), .DISPLAY_ACTIVE(active));
    // on-time counted in system clocks, rounded to grayscale periods
    always @(posedge clk)
        for (int i = 0; i < 16; i++)
            cnt[i] <= counting ? cnt[i] + {15'h0000, out[i]} : 16'h0000;
    always @(negedge counting)
        for (int i = 0; i < 16 && on_q.size() > 0; i++)
        begin
            e = on_q.pop_front();
            `CHECK("on_time", e, (cnt[i] + 16'h0004) >> 3)
        end
    // any level change without a note is an error
    always @(level)
        if (rstn === 1'b1)
        begin
            b = level_q.size() > 0 ? level_q.pop_front() : 8'hFF;
            `CHECK("level", b, {1'b0, level})
        end
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'hB40306C4));
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        level_q.push_back(8'h35);
        m.load({248'h0, 8'h35}, 1'b1);
        // values of 128*k so a short window still shows the whole on-time
        for (int i = 0; i < 16; i++)
        begin
            gs[16 * i +: 16] = {5'h00, 4'($urandom), 7'h00};
            on_q.push_back(gs[16 * i +: 16]);
        end
        m.load(gs, 1'b0);
        counting = 1'b1;
        blank = 1'b0;
        m.wait_clk(4);
        `CHECK("active", 1'b1, active)
        m.run_gs(2048);
        m.wait_clk(8);
        counting = 1'b0;
        m.load({248'h0, 8'hCA}, 1'b1);
        level_q.push_back(8'h4A);
        blank = 1'b1;
        m.wait_clk(20);
        `CHECK("active", 1'b0, active)
        print_verdict();
    end
endmodule : grayscale_pwm_double_latch_test
